/* File: logic/asf_top.sv */
// audio sample fifo path: register port, two sample fifos, serial link.
// assumes bit clock, frame sync and serial input come from the codec
// asynchronously; sync low marks the left slot, data msb first.
// Operation
// - replay off sends zero samples
// - empty fifo sends zero or last sample
// - record off discards received samples
// - full receive fifo discards new samples
// - link runs once unit enable set
// - two fifos, 24 bits by 32 entries
// - one data access moves one sample
// - lsb aligned, upper bits dropped or zero
// - empty receive fifo reads as zero
// - underrun sets flag, optional interrupt
// - underrun keeps sending zero or last
// - overrun sets flag, optional interrupt, data lost
// - left first, slot order kept
// - fill levels readable for both fifos
// - thresholds set dma and service levels
// - level interrupts gated by own enables
// - dma requests gated by own enables
// - slot selects choose replayed, recorded channels
// - flush empties both fifos only
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module asf_sync3 (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1_reg, s2_reg, s3_reg, lvl_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        lvl_reg <= s3_reg;
      end
    end
  end
  assign level = lvl_reg;
  assign rise = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
  assign fall = (s2_reg == s3_reg) && !s3_reg && lvl_reg;
endmodule

module asf_fifo (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [asf_pkg::DATA_W-1:0] wdata,
  input wire logic pop,
  output logic [asf_pkg::DATA_W-1:0] head,
  output logic [asf_pkg::CNT_W-1:0] count
);
  logic [asf_pkg::DATA_W-1:0] mem_reg [asf_pkg::DEPTH];
  logic [asf_pkg::PTR_W-1:0] wp_reg, rp_reg;
  logic [asf_pkg::CNT_W-1:0] cnt_reg;
  logic do_push, do_pop;
  assign do_pop = pop && (cnt_reg != '0);
  assign do_push = push && (cnt_reg != asf_pkg::CNT_W'(asf_pkg::DEPTH));
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem_reg[wp_reg] <= wdata;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else if (flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg <= wp_reg + asf_pkg::PTR_W'(do_push);
      rp_reg <= rp_reg + asf_pkg::PTR_W'(do_pop);
      cnt_reg <= cnt_reg + asf_pkg::CNT_W'(do_push)
        - asf_pkg::CNT_W'(do_pop);
    end
  end
  assign head = mem_reg[rp_reg];
  assign count = cnt_reg;
endmodule

module asf_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire asf_pkg::asf_bus_req_type bus_req,
  output logic [31:0] rd_data,
  input wire logic bit_clk_in,
  input wire logic frame_sync_in,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req
);
  asf_pkg::asf_ctrl_type ctrl_reg, wr_ctrl;
  asf_pkg::asf_conf_type conf_reg;
  logic tx_underrun_flag_reg, rx_overrun_flag_reg;
  logic last_fs_reg, sout_reg, irq_reg;
  logic txdr_reg, rxdr_reg;
  logic [31:0] rd_data_reg;
  logic [asf_pkg::SHIFT_W-1:0] tx_shift_reg, rx_shift_reg, rx_word;
  logic [asf_pkg::DATA_W-1:0] last_reg, tx_head, rx_head, tx_word;
  logic [asf_pkg::DATA_W-1:0] rx_sample, omask, imask;
  logic [asf_pkg::CNT_W-1:0] tx_cnt, rx_cnt;
  logic bclk_rise, bclk_fall, fs_lvl, sin_lvl;
  logic slot_start, tx_sel, rx_sel, tx_empty, rx_full;
  logic tx_push, tx_pop, rx_push, rx_pop, flush, underrun_set, overrun_set;
  logic wr_ctrl_hit, wr_stat_hit, wr_data_hit, rd_data_hit;
  logic tx_lvl, rx_lvl;

  asf_sync3 u_bclk (.core_clk(core_clk), .rst_n(rst_n),
    .async_in(bit_clk_in), .level(), .rise(bclk_rise), .fall(bclk_fall));
  asf_sync3 u_fs (.core_clk(core_clk), .rst_n(rst_n),
    .async_in(frame_sync_in), .level(fs_lvl), .rise(), .fall());
  asf_sync3 u_sin (.core_clk(core_clk), .rst_n(rst_n),
    .async_in(serial_in_line), .level(sin_lvl), .rise(), .fall());

  // bus decode
  assign wr_ctrl = asf_pkg::asf_ctrl_type'(
    bus_req.wdata[asf_pkg::CTRL_W-1:0]);
  assign wr_ctrl_hit = bus_req.wr && (bus_req.addr == asf_pkg::OFF_CTRL);
  assign wr_stat_hit = bus_req.wr && (bus_req.addr == asf_pkg::OFF_STAT);
  assign wr_data_hit = bus_req.wr && (bus_req.addr == asf_pkg::OFF_DATA);
  assign rd_data_hit = bus_req.rd && (bus_req.addr == asf_pkg::OFF_DATA);
  assign flush = wr_ctrl_hit && wr_ctrl.fifo_empty_cmd;
  assign omask = asf_pkg::asf_size_mask(ctrl_reg.out_sample_size);
  assign imask = asf_pkg::asf_size_mask(ctrl_reg.in_sample_size);

  // fifos
  assign tx_push = wr_data_hit;
  assign rx_pop = rd_data_hit;
  asf_fifo u_tx (.core_clk(core_clk), .rst_n(rst_n), .flush(flush),
    .push(tx_push), .wdata(bus_req.wdata[asf_pkg::DATA_W-1:0] & omask),
    .pop(tx_pop), .head(tx_head), .count(tx_cnt));
  asf_fifo u_rx (.core_clk(core_clk), .rst_n(rst_n), .flush(flush),
    .push(rx_push), .wdata(rx_sample), .pop(rx_pop), .head(rx_head),
    .count(rx_cnt));
  assign tx_empty = (tx_cnt == '0);
  assign rx_full = (rx_cnt == asf_pkg::CNT_W'(asf_pkg::DEPTH));

  // slot timing: sync low is the left slot, taken first
  assign slot_start = ctrl_reg.unit_enable_bit && bclk_rise
    && (fs_lvl != last_fs_reg);
  assign tx_sel = conf_reg.out_slot_select[fs_lvl];
  assign rx_sel = conf_reg.in_slot_select[last_fs_reg];
  assign tx_pop = slot_start && tx_sel && ctrl_reg.replay_enable;
  assign underrun_set = tx_pop && tx_empty;
  always_comb begin
    if (!ctrl_reg.replay_enable || !tx_sel) begin
      tx_word = '0;
    end else if (!tx_empty) begin
      tx_word = tx_head;
    end else if (ctrl_reg.underrun_last_sample_sel) begin
      tx_word = last_reg;
    end else begin
      tx_word = '0;
    end
  end
  assign rx_word = {rx_shift_reg[asf_pkg::SHIFT_W-2:0], sin_lvl};
  assign rx_sample = asf_pkg::DATA_W'(rx_word
    >> (asf_pkg::CNT_W'(asf_pkg::SHIFT_W)
    - asf_pkg::asf_size_bits(ctrl_reg.in_sample_size))) & imask;
  assign rx_push = slot_start && rx_sel && ctrl_reg.record_enable
    && !rx_full;
  assign overrun_set = slot_start && rx_sel && ctrl_reg.record_enable
    && rx_full;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= asf_pkg::CTRL_RESET;
      conf_reg <= asf_pkg::CONF_RESET;
    end else begin
      if (wr_ctrl_hit) begin
        ctrl_reg <= wr_ctrl;
        ctrl_reg.fifo_empty_cmd <= 1'b0;
      end
      if (bus_req.wr && (bus_req.addr == asf_pkg::OFF_CONF)) begin
        conf_reg <= asf_pkg::asf_conf_type'(
          bus_req.wdata[asf_pkg::CONF_W-1:0]);
      end
    end
  end

  // sticky flags, write one clears, a new event wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_underrun_flag_reg <= 1'b0;
      rx_overrun_flag_reg <= 1'b0;
    end else begin
      tx_underrun_flag_reg <= underrun_set || (tx_underrun_flag_reg
        && !(wr_stat_hit
        && bus_req.wdata[asf_pkg::STAT_UNDERRUN_BIT]));
      rx_overrun_flag_reg <= overrun_set || (rx_overrun_flag_reg
        && !(wr_stat_hit
        && bus_req.wdata[asf_pkg::STAT_OVERRUN_BIT]));
    end
  end

  // serial link shifters
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_fs_reg <= 1'b0;
      tx_shift_reg <= '0;
      rx_shift_reg <= '0;
      sout_reg <= 1'b0;
      last_reg <= '0;
    end else if (!ctrl_reg.unit_enable_bit) begin
      sout_reg <= 1'b0;
      last_fs_reg <= fs_lvl;
    end else begin
      if (bclk_rise) begin
        last_fs_reg <= fs_lvl;
        rx_shift_reg <= slot_start ? '0 : rx_word;
      end
      if (slot_start) begin
        tx_shift_reg <= {tx_word, asf_pkg::PAD_W'(0)}
          << (asf_pkg::CNT_W'(asf_pkg::DATA_W)
          - asf_pkg::asf_size_bits(ctrl_reg.out_sample_size));
      end else if (bclk_fall) begin
        sout_reg <= tx_shift_reg[asf_pkg::SHIFT_W-1];
        tx_shift_reg <= tx_shift_reg << 1;
      end
      if (tx_pop && !tx_empty) begin
        last_reg <= tx_head;
      end
    end
  end

  // levels, requests and interrupt
  assign tx_lvl = tx_cnt <= asf_pkg::CNT_W'(conf_reg.tx_fifo_threshold);
  assign rx_lvl = rx_cnt >= asf_pkg::CNT_W'(conf_reg.rx_fifo_threshold);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txdr_reg <= 1'b0;
      rxdr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      txdr_reg <= ctrl_reg.unit_enable_bit && ctrl_reg.tx_dma_en
        && tx_lvl;
      rxdr_reg <= ctrl_reg.unit_enable_bit && ctrl_reg.rx_dma_en
        && rx_lvl;
      irq_reg <= (tx_underrun_flag_reg && ctrl_reg.tx_underrun_irq_en)
        || (rx_overrun_flag_reg && ctrl_reg.rx_overrun_irq_en)
        || (tx_lvl && ctrl_reg.tx_level_irq_en)
        || (rx_lvl && ctrl_reg.rx_level_irq_en);
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= '0;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        asf_pkg::OFF_CTRL: rd_data_reg <= 32'(ctrl_reg);
        asf_pkg::OFF_CONF: rd_data_reg <= 32'(conf_reg);
        asf_pkg::OFF_STAT: rd_data_reg <= 32'({rx_cnt, 2'h0, tx_cnt,
          6'h00, rx_overrun_flag_reg, tx_underrun_flag_reg});
        asf_pkg::OFF_DATA: rd_data_reg <= (rx_cnt == '0) ? 32'h0
          : 32'(rx_head & imask);
        default: rd_data_reg <= 32'h0;
      endcase
    end else begin
      rd_data_reg <= '0;
    end
  end

  assign rd_data = rd_data_reg;
  assign serial_out_line = sout_reg;
  assign irq = irq_reg;
  assign tx_dma_req = txdr_reg;
  assign rx_dma_req = rxdr_reg;

  property p_replay_off_zero;
    @(posedge core_clk) disable iff (!rst_n)
    (slot_start && !ctrl_reg.replay_enable) |=> tx_shift_reg == '0;
  endproperty
  a_replay_off_zero: assert property (p_replay_off_zero)
    else $error("replay off but nonzero sample loaded");
  property p_record_off;
    @(posedge core_clk) disable iff (!rst_n)
    !ctrl_reg.record_enable |=> rx_cnt <= $past(rx_cnt);
  endproperty
  a_record_off: assert property (p_record_off)
    else $error("receive fifo grew with record off");
  property p_rx_bound;
    @(posedge core_clk) disable iff (!rst_n)
    rx_full |=> rx_cnt <= asf_pkg::CNT_W'(asf_pkg::DEPTH);
  endproperty
  a_rx_bound: assert property (p_rx_bound)
    else $error("receive fifo passed its depth");
  property p_empty_read;
    @(posedge core_clk) disable iff (!rst_n)
    (rd_data_hit && rx_cnt == '0) |=> rd_data == 32'h0;
  endproperty
  a_empty_read: assert property (p_empty_read)
    else $error("empty receive fifo read nonzero");
  property p_underrun;
    @(posedge core_clk) disable iff (!rst_n)
    underrun_set |=> tx_underrun_flag_reg
      ##1 (tx_underrun_flag_reg || $past(wr_stat_hit));
  endproperty
  a_underrun: assert property (p_underrun)
    else $error("underrun flag not held");
  property p_tx_req;
    @(posedge core_clk) disable iff (!rst_n)
    tx_dma_req == $past(ctrl_reg.unit_enable_bit && ctrl_reg.tx_dma_en
      && tx_cnt <= asf_pkg::CNT_W'(conf_reg.tx_fifo_threshold));
  endproperty
  a_tx_req: assert property (p_tx_req)
    else $error("tx dma request missing");
  property p_flush;
    @(posedge core_clk) disable iff (!rst_n)
    flush |=> (tx_cnt == '0) && (rx_cnt == '0) && ctrl_reg.unit_enable_bit
      == $past(wr_ctrl.unit_enable_bit);
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush did not empty fifos");
  property p_one_push;
    @(posedge core_clk) disable iff (!rst_n)
    (tx_push && !tx_pop && !flush && tx_cnt < asf_pkg::CNT_W'(asf_pkg::DEPTH))
      |=> tx_cnt == $past(tx_cnt) + 6'h01;
  endproperty
  a_one_push: assert property (p_one_push)
    else $error("data write did not add one entry");
  property p_read_mask;
    @(posedge core_clk) disable iff (!rst_n)
    rd_data_hit |=> (rd_data[asf_pkg::DATA_W-1:0] & ~$past(imask)) == '0
      && rd_data[31:asf_pkg::DATA_W] == '0;
  endproperty
  a_read_mask: assert property (p_read_mask)
    else $error("read sample has bits above size");
  c_underrun: cover property (@(posedge core_clk) disable iff (!rst_n)
    underrun_set);
  c_overrun: cover property (@(posedge core_clk) disable iff (!rst_n)
    overrun_set);
  c_record: cover property (@(posedge core_clk) disable iff (!rst_n)
    rx_push ##[1:300] rd_data_hit);
endmodule
`default_nettype wire

/* File: logic/asf_pkg.sv */
// package of the audio sample fifo path: register map, field layouts,
// reset values, bus request carrier and sample size decoding.
// assumes one core clock domain; all users write asf_pkg::name.
`default_nettype none
package asf_pkg;
  localparam int DATA_W = 24;
  localparam int DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam int ADDR_W = 4;
  localparam int SHIFT_W = 32;
  localparam int PAD_W = SHIFT_W - DATA_W;
  localparam int CTRL_W = 17;
  localparam int CONF_W = 14;
  localparam int STAT_W = 14;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CONF = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_DATA = 4'hC;
  localparam int STAT_UNDERRUN_BIT = 0;
  localparam int STAT_OVERRUN_BIT = 1;
  localparam logic [2:0] SZ_8 = 3'h0;
  localparam logic [2:0] SZ_16 = 3'h1;
  localparam logic [2:0] SZ_18 = 3'h2;
  localparam logic [2:0] SZ_20 = 3'h3;
  localparam logic [2:0] SZ_24 = 3'h4;

  typedef struct packed {
    logic [2:0] in_sample_size;
    logic [2:0] out_sample_size;
    logic rx_dma_en;
    logic tx_dma_en;
    logic rx_level_irq_en;
    logic tx_level_irq_en;
    logic rx_overrun_irq_en;
    logic tx_underrun_irq_en;
    logic fifo_empty_cmd;
    logic underrun_last_sample_sel;
    logic record_enable;
    logic replay_enable;
    logic unit_enable_bit;
  } asf_ctrl_type;

  typedef struct packed {
    logic [1:0] in_slot_select;
    logic [1:0] out_slot_select;
    logic [4:0] rx_fifo_threshold;
    logic [4:0] tx_fifo_threshold;
  } asf_conf_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } asf_bus_req_type;

  localparam asf_ctrl_type CTRL_RESET = '{in_sample_size: SZ_16,
    out_sample_size: SZ_16, default: 1'b0};
  localparam asf_conf_type CONF_RESET = '{in_slot_select: 2'h3,
    out_slot_select: 2'h3, rx_fifo_threshold: 5'h10,
    tx_fifo_threshold: 5'h10};

  function automatic logic [5:0] asf_size_bits(input logic [2:0] code);
    unique case (code)
      SZ_8: return 6'h08;
      SZ_16: return 6'h10;
      SZ_18: return 6'h12;
      SZ_20: return 6'h14;
      default: return 6'h18;
    endcase
  endfunction

  function automatic logic [DATA_W-1:0] asf_size_mask(input logic [2:0] code);
    return DATA_W'((25'h1 << asf_size_bits(code)) - 25'h1);
  endfunction
endpackage
`default_nettype wire

/* File: testbench/asf_codec_model.sv */
// codec partner: bit clock, frame sync and serial data, whole frames only.
// assumes the bench calls run() while no register access is pending.
`timescale 1ns/1ps
`default_nettype none
module asf_codec_model (
  output logic bit_clk,
  output logic frame_sync,
  output logic sdata,
  input wire logic serial_out_line
);
  logic [31:0] seen_q[$];
  logic [31:0] done_q[$];
  bit slot_q[$];
  logic [31:0] cap = '0;
  logic [31:0] prev = '0;

  initial begin
    bit_clk = 1'b0;
    frame_sync = 1'b1;
    sdata = 1'b0;
  end

  // clock stands still between runs; data line flips when left idle
  task automatic run(input int frames);
    logic [31:0] cur;
    for (int f = 0; f < frames; f++) begin
      for (int s = 0; s < 2; s++) begin
        cur = $urandom;
        for (int k = 0; k < 32; k++) begin
          frame_sync <= s[0];
          sdata <= (k == 0) ? prev[0] : cur[32-k];
          #100 bit_clk <= 1'b1;
          #100 cap = {cap[30:0], serial_out_line};
          if (k == 0) begin
            slot_q.push_back(s[0]);
            seen_q.push_back(cap);
            done_q.push_back(prev);
          end
          bit_clk <= 1'b0;
        end
        prev = cur;
      end
    end
    sdata <= ~sdata;
  endtask
endmodule
`default_nettype wire

/* File: testbench/audio_sample_fifo_path_bench.sv */
// bench of the sample fifo path: register tasks, fifo and link model.
// assumes the codec model in its own file and the design package.
`timescale 1ns/1ps
`default_nettype none
module audio_sample_fifo_path_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  asf_pkg::asf_bus_req_type bus_req = '0;
  logic [31:0] rd_data;
  logic bit_clk, frame_sync, sdata, serial_out_line;
  logic irq, tx_dma_req, rx_dma_req;
  int errors = 0;
  int checks_done = 0;
  int sizes[5] = '{8, 16, 18, 20, 24};
  logic [31:0] txq[$];
  logic [31:0] rxq[$];
  logic [31:0] expq[$];
  logic [31:0] last = '0;
  logic [31:0] c, cf, d;
  logic tx_underrun_flag = 1'b0;
  logic rx_overrun_flag = 1'b0;

  always #12.5 core_clk = ~core_clk;

  asf_top asf_top_inst (.core_clk(core_clk), .rst_n(rst_n),
    .bus_req(bus_req), .rd_data(rd_data), .bit_clk_in(bit_clk),
    .frame_sync_in(frame_sync), .serial_in_line(sdata),
    .serial_out_line(serial_out_line), .irq(irq),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
  asf_codec_model asf_codec_model_inst (.bit_clk(bit_clk),
    .frame_sync(frame_sync), .sdata(sdata),
    .serial_out_line(serial_out_line));

  task automatic close_out();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    bus_req <= '{1'b1, 1'b0, a, v};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    bus_req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge core_clk);
    bus_req <= '0;
    #1 chk(rd_data, e);
    @(posedge core_clk);
  endtask

  function automatic logic [31:0] stat_exp();
    return {10'h0, 6'(rxq.size()), 2'h0, 6'(txq.size()), 6'h0,
      rx_overrun_flag, tx_underrun_flag};
  endfunction

  task automatic outs_chk();
    logic tl, rl;
    tl = txq.size() <= cf[4:0];
    rl = rxq.size() >= cf[9:5];
    chk({29'h0, irq, tx_dma_req, rx_dma_req}, {29'h0,
      (tx_underrun_flag & c[5]) | (rx_overrun_flag & c[6])
      | (tl & c[7]) | (rl & c[8]),
      c[9] & tl, c[10] & rl});
  endtask

  task automatic drain();
    int n;
    n = rxq.size();
    for (int k = 0; k <= n; k++) begin
      d = (k < n) ? rxq.pop_front() : 32'h0;
      rdchk(asf_pkg::OFF_DATA, d);
    end
  endtask

  task automatic link(input int frames);
    bit s;
    logic [31:0] w, dw;
    int osz, isz;
    osz = sizes[c[13:11]];
    isz = sizes[c[16:14]];
    asf_codec_model_inst.run(frames);
    repeat (10) @(posedge core_clk);
    while (asf_codec_model_inst.slot_q.size() > 0) begin
      s = asf_codec_model_inst.slot_q.pop_front();
      dw = asf_codec_model_inst.done_q.pop_front();
      w = 32'h0;
      if (c[1] && cf[s ? 11 : 10]) begin
        if (txq.size() > 0) begin
          last = txq.pop_front();
          w = last;
        end else begin
          tx_underrun_flag = 1'b1;
          w = c[3] ? last : 32'h0;
        end
      end
      expq.push_back(w << (32 - osz));
      if (c[2] && cf[s ? 12 : 13]) begin
        if (rxq.size() < 32) begin
          rxq.push_back(dw >> (32 - isz));
        end else begin
          rx_overrun_flag = 1'b1;
        end
      end
      w = asf_codec_model_inst.seen_q.pop_front();
      chk(w, expq.pop_front());
    end
  endtask

  initial begin
    #2000000;
    errors++;
    close_out();
  end

  initial begin
    void'($urandom(32'h379D));
    repeat (10) @(posedge core_clk);
    chk({28'h0, irq, tx_dma_req, rx_dma_req, serial_out_line}, 32'h0);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdchk(asf_pkg::OFF_CTRL, 32'(asf_pkg::CTRL_RESET));
    rdchk(asf_pkg::OFF_CONF, 32'(asf_pkg::CONF_RESET));
    rdchk(asf_pkg::OFF_STAT, 32'h0);
    rdchk(4'h2, 32'h0);
    rdchk(asf_pkg::OFF_DATA, 32'h0);
    c = 32'h1;
    wr(asf_pkg::OFF_CTRL, c);
    asf_codec_model_inst.run(1);
    repeat (10) @(posedge core_clk);
    asf_codec_model_inst.slot_q.delete();
    asf_codec_model_inst.seen_q.delete();
    asf_codec_model_inst.done_q.delete();
    expq.push_back(32'h0);
    for (int i = 0; i < 5; i++) begin
      c = 32'h1;
      c[1] = (i != 1);
      c[2] = (i != 2);
      c[3] = (i == 2) || (i == 3);
      c[10:5] = 6'($urandom) | 6'h2;
      c[13:11] = 3'(i);
      c[16:14] = 3'(4 - i);
      cf = {18'h0, (i == 4) ? 2'h2 : 2'h3, (i == 3) ? 2'h1 : 2'h3,
        10'($urandom)};
      wr(asf_pkg::OFF_CTRL, c);
      wr(asf_pkg::OFF_CONF, cf);
      repeat (3) begin
        d = $urandom;
        wr(asf_pkg::OFF_DATA, d);
        txq.push_back(d & ((32'h1 << sizes[i]) - 32'h1));
      end
      rdchk(asf_pkg::OFF_STAT, stat_exp());
      outs_chk();
      link(2);
      rdchk(asf_pkg::OFF_STAT, stat_exp());
      outs_chk();
      wr(asf_pkg::OFF_STAT, 32'h3);
      tx_underrun_flag = 1'b0;
      rx_overrun_flag = 1'b0;
      drain();
      wr(asf_pkg::OFF_CTRL, c | 32'h10);
      txq.delete();
      rdchk(asf_pkg::OFF_CTRL, c);
      rdchk(asf_pkg::OFF_STAT, 32'h0);
    end
    c[1] = 1'b0;
    c[2] = 1'b1;
    c[16:14] = 3'h4;
    cf[13:12] = 2'h3;
    wr(asf_pkg::OFF_CTRL, c);
    wr(asf_pkg::OFF_CONF, cf);
    link(17);
    rdchk(asf_pkg::OFF_STAT, stat_exp());
    outs_chk();
    drain();
    close_out();
  end
endmodule
`default_nettype wire
